// File: pkg/tsg_pkg.sv
package tsg_pkg;

	// timing, all copy and program times are upper bounds
	localparam int MCLK_NS    = 10;
	localparam int T_COPYR_NS = 20000;
	localparam int T_COPYW_NS = 40000;
	localparam int T_PROG_NS  = 40000;
	localparam int T_POR_NS   = 20000;
	localparam logic [11:0] COPYR_CYC = 12'(T_COPYR_NS / MCLK_NS);
	localparam logic [11:0] COPYW_CYC = 12'(T_COPYW_NS / MCLK_NS);
	localparam logic [11:0] PROG_CYC  = 12'(T_PROG_NS / MCLK_NS);
	localparam logic [11:0] POR_CYC   = 12'(T_POR_NS / MCLK_NS);

	// bus addressing and opcodes
	localparam logic [3:0] DEV_ID_HI    = 4'h9;
	localparam logic [7:0] GC_WRITE     = 8'h00;
	localparam logic [7:0] GC_RELATCH   = 8'h04;
	localparam logic [7:0] GC_RESET     = 8'h06;
	localparam logic [7:0] OP_NV2V_CODE = 8'hB8;
	localparam logic [7:0] OP_V2NV_CODE = 8'h48;

	// pointer values
	localparam logic [7:0] PTR_TEMP    = 8'h00;
	localparam logic [7:0] PTR_CFG     = 8'h01;
	localparam logic [7:0] PTR_LOW_LIMIT    = 8'h02;
	localparam logic [7:0] PTR_HIGH_LIMIT   = 8'h03;
	localparam logic [7:0] PTR_NVCFG   = 8'h11;
	localparam logic [7:0] PTR_NVTLOW  = 8'h12;
	localparam logic [7:0] PTR_NVTHIGH = 8'h13;

	// configuration fields
	localparam int LOCK_POS     = 2;
	localparam int LOCKDOWN_POS = 1;
	localparam int BUSY_POS     = 0;
	localparam logic [15:0] LOCK_MASK     = 16'(1) << LOCK_POS;
	localparam logic [15:0] LOCKDOWN_MASK = 16'(1) << LOCKDOWN_POS;
	localparam logic [15:0] BUSY_MASK     = 16'(1) << BUSY_POS;

	// reset and factory values
	localparam logic [15:0] VOL_RST     = 16'h0000;
	localparam logic [15:0] NVCFG_DEF   = 16'h0000;
	localparam logic [15:0] NVTLOW_DEF  = 16'h4B00;
	localparam logic [15:0] NVTHIGH_DEF = 16'h5000;
	localparam logic [4:0]  SYNC_RST    = 5'h03;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_AACK = 7'h04,
		S_RX   = 7'h08,
		S_RACK = 7'h10,
		S_TX   = 7'h20,
		S_TACK = 7'h40
	} tsg_state_e;

	typedef enum logic [6:0] {
		OP_NONE    = 7'h01,
		OP_NVCFG   = 7'h02,
		OP_NVTLOW  = 7'h04,
		OP_NVTHIGH = 7'h08,
		OP_COPYR   = 7'h10,
		OP_COPYW   = 7'h20,
		OP_BOOT    = 7'h40
	} tsg_op_e;

endpackage

// File: rtl/tsg_gate.sv
module tsg_gate
	import tsg_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// two-wire bus
	input  wire logic        scl,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// straps and sensor
	input  wire logic [2:0]  address_select_pins,
	input  wire logic [15:0] temp_value,
	input  wire logic        factory_load,
	// status
	output logic             nonvolatile_busy_flag,
	output logic             register_lock_bit,
	output logic             permanent_lockdown_bit,
	output logic      [15:0] cfg_volatile,
	output logic      [15:0] low_limit,
	output logic      [15:0] high_limit
);

	logic [4:0]  s_w;
	logic        scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
	logic        tload, tdone, locked_w, copy_busy, rd_ok_w;
	logic        rx_end, addr_end, is_op_w, pdat_lock;
	logic [11:0] tcyc;
	logic [15:0] rd_val_w, nvcfg_keep;
	tsg_state_e  st_q, st_d;
	tsg_op_e     pend_q, pend_d, bkind_q, bkind_d;
	logic [7:0]  sh_q, sh_d, ptr_q, ptr_d, dhi_q, dhi_d;
	logic [3:0]  bitc_q, bitc_d;
	logic [1:0]  nb_q, nb_d;
	logic        rw_q, rw_d, gc_q, gc_d, cmd_q, cmd_d, ack_q, ack_d;
	logic        oe_q, oe_d, busy_q, busy_d, boot_q, boot_d;
	logic        scl_p, scl_p_d, sda_p, sda_p_d;
	logic [15:0] tx_q, tx_d, pdat_q, pdat_d;
	logic [2:0]  addr_q, addr_d;
	logic [15:0] vcfg_q, vcfg_d, vtlow_q, vtlow_d, vthigh_q, vthigh_d;
	logic [15:0] nvcfg_q, nvcfg_d, nvtlow_q, nvtlow_d, nvthigh_q, nvthigh_d;
	logic [11:0] bcnt_q;

	function automatic logic is_vol(input logic [7:0] p);
		return p == PTR_CFG || p == PTR_LOW_LIMIT || p == PTR_HIGH_LIMIT;
	endfunction

	function automatic logic is_wr(input logic [7:0] p);
		return is_vol(p) || p == PTR_NVCFG || p == PTR_NVTLOW
			|| p == PTR_NVTHIGH;
	endfunction

	tsg_sync #(.W(5), .RST(SYNC_RST)) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({address_select_pins, sda_i, scl}),
		.q    (s_w)
	);

	tsg_timer u_tmr (
		.mclk   (mclk),
		.rst    (rst),
		.load   (tload),
		.cycles (tcyc),
		.done   (tdone)
	);

	assign scl_s     = s_w[0];
	assign sda_s     = s_w[1];
	assign scl_rise  = scl_s & ~scl_p;
	assign scl_fall  = ~scl_s & scl_p;
	assign start_c   = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c    = scl_s & scl_p & ~sda_p & sda_s;
	assign locked_w  = nvcfg_q[LOCK_POS] | nvcfg_q[LOCKDOWN_POS];
	assign copy_busy = busy_q & (bkind_q == OP_COPYR || bkind_q == OP_BOOT);
	assign rx_end    = st_q == S_RX && scl_fall && bitc_q == 4'h8;
	assign addr_end  = st_q == S_ADDR && scl_fall && bitc_q == 4'h8;
	assign is_op_w   = sh_q == OP_NV2V_CODE || sh_q == OP_V2NV_CODE;
	assign pdat_lock  = pdat_q[LOCK_POS];
	assign nvcfg_keep = nvcfg_q & ~LOCK_MASK;
	// reads allowed while busy
	assign rd_ok_w = !busy_q || ptr_q == PTR_TEMP
		|| (is_vol(ptr_q) && !copy_busy);

	assign sda_o                  = 1'b0;
	assign sda_oe                 = oe_q;
	assign nonvolatile_busy_flag  = busy_q;
	assign register_lock_bit      = nvcfg_q[LOCK_POS];
	assign permanent_lockdown_bit = nvcfg_q[LOCKDOWN_POS];
	assign cfg_volatile           = vcfg_q;
	assign low_limit              = vtlow_q;
	assign high_limit             = vthigh_q;

	always_comb begin
		case (ptr_q)
			PTR_TEMP:    rd_val_w = temp_value;
			PTR_CFG:     rd_val_w = (vcfg_q & ~BUSY_MASK)
				| ({16{busy_q}} & BUSY_MASK);
			PTR_LOW_LIMIT:    rd_val_w = vtlow_q;
			PTR_HIGH_LIMIT:   rd_val_w = vthigh_q;
			PTR_NVCFG:   rd_val_w = nvcfg_q;
			PTR_NVTLOW:  rd_val_w = nvtlow_q;
			PTR_NVTHIGH: rd_val_w = nvthigh_q;
			default:     rd_val_w = VOL_RST;
		endcase
	end

	// bus engine, command gate and volatile registers
	always_comb begin
		logic        ack_v;
		logic [15:0] data_v;
		ack_v    = 1'b0;
		data_v   = {dhi_q, sh_q};
		st_d     = st_q;
		sh_d     = sh_q;
		bitc_d   = bitc_q;
		nb_d     = nb_q;
		rw_d     = rw_q;
		gc_d     = gc_q;
		cmd_d    = cmd_q;
		ack_d    = ack_q;
		oe_d     = oe_q;
		tx_d     = tx_q;
		ptr_d    = ptr_q;
		dhi_d    = dhi_q;
		pend_d   = pend_q;
		pdat_d   = pdat_q;
		busy_d   = busy_q;
		bkind_d  = bkind_q;
		boot_d   = boot_q;
		addr_d   = addr_q;
		vcfg_d   = vcfg_q;
		vtlow_d  = vtlow_q;
		vthigh_d = vthigh_q;
		scl_p_d  = scl_s;
		sda_p_d  = sda_s;
		tload    = 1'b0;
		tcyc     = COPYR_CYC;
		if (boot_q) begin
			boot_d  = 1'b0;
			busy_d  = 1'b1;
			bkind_d = OP_BOOT;
			tload   = 1'b1;
			tcyc    = POR_CYC;
		end
		if (tdone) begin
			busy_d = 1'b0;
			if (bkind_q == OP_COPYR || bkind_q == OP_BOOT) begin
				vcfg_d   = nvcfg_q;
				vtlow_d  = nvtlow_q;
				vthigh_d = nvthigh_q;
			end
			if (bkind_q == OP_BOOT)
				addr_d = s_w[4:2];
		end
		if (start_c) begin
			st_d   = S_ADDR;
			bitc_d = 4'h0;
			oe_d   = 1'b0;
			pend_d = OP_NONE;
		end else if (stop_c) begin
			st_d   = S_IDLE;
			oe_d   = 1'b0;
			pend_d = OP_NONE;
			if (pend_q != OP_NONE && !busy_q) begin
				busy_d  = 1'b1;
				bkind_d = pend_q;
				tload   = 1'b1;
				tcyc    = pend_q == OP_COPYR ? COPYR_CYC
					: pend_q == OP_COPYW ? COPYW_CYC : PROG_CYC;
			end
		end else begin
			unique case (st_q)
				S_IDLE: begin
				end
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						sh_d   = {sh_q[6:0], sda_s};
						bitc_d = bitc_q + 4'h1;
					end else if (scl_fall && bitc_q == 4'h8) begin
						bitc_d = 4'h0;
						if (st_q == S_ADDR) begin
							st_d  = S_AACK;
							rw_d  = sh_q[0];
							gc_d  = sh_q == GC_WRITE;
							cmd_d = 1'b0;
							nb_d  = 2'h0;
							tx_d  = rd_val_w;
							if (sh_q[7:1] == {DEV_ID_HI, addr_q})
								ack_v = !sh_q[0] || rd_ok_w;
							else
								ack_v = sh_q == GC_WRITE;
						end else begin
							st_d = S_RACK;
							nb_d = nb_q == 2'h3 ? nb_q : nb_q + 2'h1;
							if (gc_q) begin
								ack_v = nb_q == 2'h0 && !busy_q
									&& (sh_q == GC_RELATCH
									|| sh_q == GC_RESET);
								if (ack_v) begin
									addr_d = s_w[4:2];
									boot_d = sh_q == GC_RESET;
								end
							end else if (nb_q == 2'h0) begin
								if (is_op_w) begin
									cmd_d = 1'b1;
									ack_v = !busy_q;
									if (!busy_q && !locked_w)
										pend_d = sh_q == OP_NV2V_CODE
											? OP_COPYR
											: OP_COPYW;
								end else begin
									ptr_d = sh_q;
									ack_v = 1'b1;
								end
							end else if (nb_q == 2'h1) begin
								dhi_d = sh_q;
								ack_v = cmd_q || !is_wr(ptr_q)
									|| !busy_q;
							end else begin
								ack_v = 1'b1;
								if (nb_q == 2'h2 && !cmd_q) begin
									case (ptr_q)
										PTR_CFG:
											if (!locked_w)
												vcfg_d = data_v;
										PTR_LOW_LIMIT:
											if (!locked_w)
												vtlow_d = data_v;
										PTR_HIGH_LIMIT:
											if (!locked_w)
												vthigh_d = data_v;
										PTR_NVCFG:
											if (!nvcfg_q[LOCKDOWN_POS]) begin
												pend_d = OP_NVCFG;
												pdat_d = locked_w
													? nvcfg_keep
													| (data_v & LOCK_MASK)
													: data_v;
											end
										PTR_NVTLOW, PTR_NVTHIGH:
											if (!locked_w) begin
												pend_d = ptr_q == PTR_NVTLOW
													? OP_NVTLOW : OP_NVTHIGH;
												pdat_d = data_v;
											end
										default: begin
										end
									endcase
								end
							end
						end
						ack_d = ack_v;
						oe_d  = ack_v;
					end
				end
				S_AACK: if (scl_fall) begin
					oe_d = 1'b0;
					if (!ack_q) begin
						st_d = S_IDLE;
					end else if (rw_q) begin
						st_d = S_TX;
						oe_d = ~tx_q[15];
					end else begin
						st_d = S_RX;
					end
				end
				S_RACK: if (scl_fall) begin
					oe_d = 1'b0;
					st_d = ack_q ? S_RX : S_IDLE;
				end
				S_TX: if (scl_rise) begin
					bitc_d = bitc_q + 4'h1;
				end else if (scl_fall) begin
					tx_d = {tx_q[14:0], 1'b0};
					if (bitc_q == 4'h8) begin
						oe_d   = 1'b0;
						st_d   = S_TACK;
						bitc_d = 4'h0;
					end else begin
						oe_d = ~tx_q[14];
					end
				end
				S_TACK: if (scl_rise) begin
					ack_d = ~sda_s;
				end else if (scl_fall) begin
					st_d = ack_q ? S_TX : S_IDLE;
					oe_d = ack_q & ~tx_q[15];
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= S_IDLE;
			sh_q <= 8'h00;
			bitc_q <= 4'h0;
			nb_q <= 2'h0;
			{rw_q, gc_q, cmd_q, ack_q, oe_q} <= 5'h00;
			tx_q <= VOL_RST;
			ptr_q <= PTR_TEMP;
			dhi_q <= 8'h00;
			pend_q <= OP_NONE;
			pdat_q <= VOL_RST;
			busy_q <= 1'b1;
			bkind_q <= OP_BOOT;
			boot_q <= 1'b1;
			addr_q <= 3'h0;
			{vcfg_q, vtlow_q, vthigh_q} <= {3{VOL_RST}};
			{scl_p, sda_p} <= 2'h3;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			bitc_q <= bitc_d;
			nb_q <= nb_d;
			{rw_q, gc_q, cmd_q, ack_q, oe_q} <= {rw_d, gc_d, cmd_d, ack_d, oe_d};
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			dhi_q <= dhi_d;
			pend_q <= pend_d;
			pdat_q <= pdat_d;
			busy_q <= busy_d;
			bkind_q <= bkind_d;
			boot_q <= boot_d;
			addr_q <= addr_d;
			{vcfg_q, vtlow_q, vthigh_q} <= {vcfg_d, vtlow_d, vthigh_d};
			{scl_p, sda_p} <= {scl_p_d, sda_p_d};
		end
	end

	// nonvolatile cells, untouched by any reset
	always_comb begin
		nvcfg_d   = nvcfg_q;
		nvtlow_d  = nvtlow_q;
		nvthigh_d = nvthigh_q;
		if (factory_load) begin
			nvcfg_d   = NVCFG_DEF;
			nvtlow_d  = NVTLOW_DEF;
			nvthigh_d = NVTHIGH_DEF;
		end else if (tdone) begin
			case (bkind_q)
				OP_NVCFG:   nvcfg_d = pdat_q;
				OP_NVTLOW:  nvtlow_d = pdat_q;
				OP_NVTHIGH: nvthigh_d = pdat_q;
				OP_COPYW: begin
					nvcfg_d   = (vcfg_q & ~(LOCK_MASK | LOCKDOWN_MASK))
						| (nvcfg_q & (LOCK_MASK | LOCKDOWN_MASK));
					nvtlow_d  = vtlow_q;
					nvthigh_d = vthigh_q;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		nvcfg_q   <= nvcfg_d;
		nvtlow_q  <= nvtlow_d;
		nvthigh_q <= nvthigh_d;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			bcnt_q <= 12'h000;
		else
			bcnt_q <= busy_q ? bcnt_q + 12'h001 : 12'h000;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_lock_vol_stable: assert property (locked_w && !(tdone && copy_busy)
		|=> $stable({vcfg_q, vtlow_q, vthigh_q}))
		else $error("volatile register changed while locked");
	a_lock_nv_stable: assert property (locked_w && !factory_load
		|=> $stable({nvtlow_q, nvthigh_q}))
		else $error("nv limit changed while locked");
	a_lock_clear_path: assert property ($fell(register_lock_bit)
		&& !$past(factory_load)
		|-> $past(tdone) && $past(bkind_q) == OP_NVCFG && !$past(pdat_lock))
		else $error("lock bit cleared by other means");
	a_lock_only_bit: assert property (register_lock_bit &&
		!permanent_lockdown_bit && !factory_load |=> $stable(nvcfg_keep))
		else $error("nv config bits changed while locked");
	a_lockdown_sticky: assert property (permanent_lockdown_bit
		&& !factory_load |=> permanent_lockdown_bit ##1 permanent_lockdown_bit)
		else $error("lockdown bit cleared");
	a_lockdown_nvcfg: assert property (permanent_lockdown_bit
		&& !factory_load |=> $stable(nvcfg_q))
		else $error("nv config changed under lockdown");
	a_busy_data_nack: assert property (rx_end && !gc_q && nb_q == 2'h1
		&& !cmd_q && is_wr(ptr_q) && busy_q |=> st_q == S_RACK && !oe_q)
		else $error("busy data byte not refused");
	a_busy_read_nack: assert property (addr_end && busy_q
		&& sh_q == {DEV_ID_HI, addr_q, 1'b1} && is_wr(ptr_q) && !is_vol(ptr_q)
		|=> !oe_q [*2])
		else $error("busy nv read address acknowledged");
	a_copyr_read_nack: assert property (addr_end && copy_busy
		&& sh_q == {DEV_ID_HI, addr_q, 1'b1} && is_vol(ptr_q) |=> !oe_q)
		else $error("volatile read acknowledged during copy-in");
	a_opcode_ptr: assert property (rx_end && !gc_q && nb_q == 2'h0
		&& is_op_w |=> $stable(ptr_q) && cmd_q)
		else $error("opcode changed the pointer");
	a_busy_op_nack: assert property (rx_end && !gc_q && nb_q == 2'h0
		&& is_op_w && busy_q |=> !oe_q && pend_q == OP_NONE)
		else $error("busy opcode acknowledged or armed");
	a_abort_start: assert property (start_c |=> pend_q == OP_NONE)
		else $error("pending copy survived repeated start");
	a_boot_copy: assert property (boot_q |=> busy_q && bkind_q == OP_BOOT)
		else $error("reset copy not started");
	a_busy_bound: assert property (busy_q |-> bcnt_q < COPYW_CYC)
		else $error("busy held past the longest copy time");

	c_copy_in: cover property (stop_c && pend_q == OP_COPYR && !busy_q);
	c_copy_out: cover property (stop_c && pend_q == OP_COPYW && !busy_q);
	c_nv_prog: cover property (tdone && bkind_q == OP_NVCFG);
	c_busy_nack: cover property (rx_end && busy_q && !cmd_q && nb_q == 2'h1);

endmodule

// File: rtl/tsg_sync.sv
module tsg_sync
	import tsg_pkg::*;
#(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// pins in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] m_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			m_q <= RST;
			q   <= RST;
		end else begin
			m_q <= d;
			q   <= m_q;
		end
	end

endmodule

// File: rtl/tsg_timer.sv
module tsg_timer
	import tsg_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// start and end of a timed operation
	input  wire logic        load,
	input  wire logic [11:0] cycles,
	output logic             done
);

	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	logic        done_d;

	// done comes exactly cycles edges after load
	always_comb begin
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (load) begin
			cnt_d = cycles - 12'h001;
		end else if (cnt_q != 12'h000) begin
			cnt_d  = cnt_q - 12'h001;
			done_d = (cnt_q == 12'h001);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= 12'h000;
			done  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done  <= done_d;
		end
	end

endmodule

// File: sim/tsg_gate_tb.sv
module tsg_gate_tb
	import tsg_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		string       nm;
		logic [15:0] v;
	} tsg_note_s;

	logic        mclk = 1'b0;
	logic        rst;
	logic        scl;
	logic        m_pull;
	logic        sda_o;
	logic        sda_oe;
	logic [2:0]  pins;
	logic [15:0] temp_value;
	logic        factory_load;
	logic        busy;
	logic        lock;
	logic        ldn;
	logic [15:0] low_limit;
	logic [15:0] high_limit;
	logic [15:0] cfg;
	logic        obs_v;
	logic [15:0] obs_d;
	logic [7:0]  wa;
	logic [15:0] v1;
	logic [15:0] v2;
	logic [31:0] seed = 32'hb93a_2888;
	tsg_note_s   exp_q[$];
	int          err_total;
	int          n_checks;
	wire         sda;

	assign sda = !((sda_oe & !sda_o) | m_pull);

	always #5 mclk = ~mclk;

	tsg_gate i_tsg_gate (
		.mclk(mclk), .rst(rst), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .address_select_pins(pins),
		.temp_value(temp_value), .factory_load(factory_load),
		.nonvolatile_busy_flag(busy), .register_lock_bit(lock),
		.permanent_lockdown_bit(ldn), .cfg_volatile(cfg),
		.low_limit(low_limit), .high_limit(high_limit));

	tsg_master i_tsg_master (
		.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(m_pull));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic rnd(output logic [15:0] v);
		seed = xs(seed);
		v = seed[15:0];
	endtask

	task automatic give_verdict();
		if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen, e);
		n_checks++;
		if (seen !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, seen);
		end
	endtask

	// watcher: oldest note against each observed result
	always @(posedge mclk) begin
		tsg_note_s n;
		if (obs_v) begin
			if (exp_q.size() == 0) begin
				err_total++;
			end else begin
				n = exp_q.pop_front();
				check(n.nm, obs_d, n.v);
			end
		end
	end

	task automatic note(input string nm, input logic [15:0] e, v);
		exp_q.push_back('{nm, e});
		obs_d <= v;
		obs_v <= 1'b1;
		@(posedge mclk);
		obs_v <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic tx(input logic [7:0] b, input logic e);
		logic [7:0] x;
		logic       k;
		i_tsg_master.byte_io(b, x);
		i_tsg_master.bit_io(1'b1, k);
		note("ack", 16'(e), 16'(!k));
	endtask

	// ea: acks of address, pointer, upper, lower; rs ends by restart
	task automatic wr(input logic [7:0] a, p, input logic [15:0] d,
		input int n, input logic [3:0] ea, input logic rs);
		i_tsg_master.start();
		tx(a, ea[3]);
		if (ea[3]) tx(p, ea[2]);
		if (n > 0 && ea[2]) tx(d[15:8], ea[1]);
		if (n > 1 && ea[1]) tx(d[7:0], ea[0]);
		if (rs) i_tsg_master.start();
		i_tsg_master.stop();
	endtask

	task automatic rd(input logic sp, input logic [7:0] p, input logic ea,
		input logic [15:0] ed);
		logic [15:0] r;
		logic        k;
		i_tsg_master.start();
		if (sp) begin
			tx(wa, 1'b1);
			tx(p, 1'b1);
			i_tsg_master.start();
		end
		tx(wa | 8'h01, ea);
		if (ea) begin
			i_tsg_master.byte_io(8'hff, r[15:8]);
			i_tsg_master.bit_io(1'b0, k);
			i_tsg_master.byte_io(8'hff, r[7:0]);
			i_tsg_master.bit_io(1'b1, k);
			note("read data", ed, r);
		end
		i_tsg_master.stop();
	endtask

	task automatic idle_wait();
		int i;
		for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge mclk);
		if (i == 5000) begin
			err_total++;
			give_verdict();
		end
	endtask

	initial begin
		rst = 1'b1;
		factory_load = 1'b0;
		obs_v = 1'b0;
		obs_d = 16'h0000;
		rnd(v1);
		pins = v1[2:0];
		wa = {DEV_ID_HI, pins, 1'b0};
		rnd(temp_value);
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		factory_load <= 1'b1;
		@(posedge mclk);
		factory_load <= 1'b0;
		idle_wait();
		note("low", NVTLOW_DEF, low_limit);
		note("high", NVTHIGH_DEF, high_limit);
		note("cfg", NVCFG_DEF, cfg);
		rnd(v1);
		v1 &= 16'hff80;
		wr(wa, PTR_LOW_LIMIT, v1, 2, 4'hf, 0);
		note("low", v1, low_limit);
		// copy-out, then refused and allowed traffic while busy
		wr(wa, OP_V2NV_CODE, 0, 0, 4'hc, 0);
		note("busy", 1, busy);
		rd(1, PTR_TEMP, 1, temp_value);
		rd(1, PTR_CFG, 1, BUSY_MASK);
		rd(1, PTR_NVTLOW, 0, 0);
		wr(wa, PTR_LOW_LIMIT, ~v1, 2, 4'hc, 0);
		wr(wa, PTR_NVCFG, 0, 2, 4'hc, 0);
		wr(wa, OP_NV2V_CODE, 0, 0, 4'h8, 0);
		wr(8'h00, GC_RESET, 0, 0, 4'h8, 0);
		wr(8'h00, GC_RELATCH, 0, 0, 4'h8, 0);
		idle_wait();
		note("low", v1, low_limit);
		// copy-in restores the stored value
		rnd(v2);
		v2 &= 16'hff80;
		wr(wa, PTR_LOW_LIMIT, v2, 2, 4'hf, 0);
		wr(wa, OP_NV2V_CODE, 0, 0, 4'hc, 0);
		rd(1, PTR_LOW_LIMIT, 0, 0);
		idle_wait();
		note("low", v1, low_limit);
		// copy-in aborted by repeated start, pointer kept
		wr(wa, PTR_LOW_LIMIT, v2, 2, 4'hf, 0);
		wr(wa, OP_NV2V_CODE, 0, 0, 4'hc, 1);
		note("busy", 0, busy);
		rd(0, 0, 1, v2);
		// lock
		wr(wa, PTR_NVCFG, LOCK_MASK, 2, 4'hf, 0);
		idle_wait();
		note("lock", 1, lock);
		wr(wa, PTR_LOW_LIMIT, v1, 2, 4'hf, 0);
		note("low", v2, low_limit);
		wr(wa, OP_NV2V_CODE, 0, 0, 4'hc, 0);
		note("busy", 0, busy);
		note("low", v2, low_limit);
		wr(wa, PTR_NVCFG, LOCK_MASK | LOCKDOWN_MASK, 2, 4'hf, 0);
		idle_wait();
		note("lockdown", 0, ldn);
		wr(8'h00, GC_RESET, 0, 0, 4'hc, 0);
		idle_wait();
		note("lock", 1, lock);
		note("low", v1, low_limit);
		note("cfg", LOCK_MASK, cfg);
		wr(wa, PTR_NVCFG, 16'h0000, 2, 4'hf, 0);
		idle_wait();
		note("lock", 0, lock);
		// lockdown
		wr(wa, PTR_NVCFG, LOCK_MASK | LOCKDOWN_MASK, 2, 4'hf, 0);
		idle_wait();
		note("lockdown", 1, ldn);
		wr(wa, PTR_NVCFG, 16'h0000, 2, 4'hf, 0);
		idle_wait();
		note("lock", 1, lock);
		note("lockdown", 1, ldn);
		wr(wa, OP_V2NV_CODE, 0, 0, 4'hc, 0);
		note("busy", 0, busy);
		wr(wa, PTR_LOW_LIMIT, v2, 2, 4'hf, 0);
		note("low", v1, low_limit);
		give_verdict();
	end
endmodule

// File: sim/tsg_master.sv
module tsg_master (
	// clock of the bench
	input  wire logic mclk,
	// resolved data line
	input  wire logic sda,
	// master drives
	output logic      scl,
	output logic      sda_pull
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic hold();
		repeat (4) @(posedge mclk);
	endtask

	// start or repeated start: sda falls while scl high
	task automatic start();
		sda_pull <= 1'b0;
		hold();
		scl <= 1'b1;
		hold();
		sda_pull <= 1'b1;
		hold();
		scl <= 1'b0;
	endtask

	// one bit, msb-first framing done by caller, sampled half a clock before scl falls
	task automatic bit_io(input logic b, output logic s);
		sda_pull <= !b;
		hold();
		scl <= 1'b1;
		hold();
		@(negedge mclk);
		s = sda;
		@(posedge mclk);
		scl <= 1'b0;
	endtask

	task automatic byte_io(input logic [7:0] b, output logic [7:0] s);
		for (int i = 7; i >= 0; i--) bit_io(b[i], s[i]);
	endtask

	// stop: sda rises while scl high, then bus idles high
	task automatic stop();
		sda_pull <= 1'b1;
		hold();
		scl <= 1'b1;
		hold();
		sda_pull <= 1'b0;
		hold();
	endtask
endmodule
